// ===== hdl/dpc_host.sv
// host controller driving one port of a two-port static memory
// Notes on behaviour
// R1 - during any read the read/write line stays high throughout.
// R2 - flag reads use select-controlled access, never continuous address-driven reads.
// R3 - device writes while select and read/write both low; first rise ends it.
// R4 - read/write is high whenever the address lines change.
// R5 - device floats data lines during a write even with output enable low.
// R6 - writer's busy stays high; written data reaches the reading port.
// R7 - flag request: data bit zero low, chip select high, flag select low.
// R8 - all flags are released at start of operation.
// R9 - simultaneous flag requests: device grants exactly one port.
// R10 - simultaneous same-address access: busy goes low on exactly one port.
// R11 - slave configuration: active busy holds off the write until released.
// R12 - mailbox location for port interrupts is address 1FFE.
// R13 - master configuration: busy low on losing port on match, high on mismatch.
// R14 - flag read after own write returns the updated ownership value.
// R15 - array: chip select low, flag select high; flags: the reverse.
// R16 - write to other port's mailbox sets its interrupt; mailbox read clears it.
module dpc_host
   import dpc_pkg::*;
#(
   parameter int unsigned READ_CYCLES = READ_CYC,
   parameter int unsigned WRITE_CYCLES = WRITE_CYC,
   parameter int unsigned RECOVER_CYCLES = RECOVER_CYC
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // user request
   input wire logic req_i,
   input wire logic we_i,
   input wire logic flag_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   output logic ready_o,
   output logic done_o,
   output logic [DATA_W-1:0] rdata_o,
   output logic irq_o,
   // memory port pins
   output logic ce_n_o,
   output logic oe_n_o,
   output logic rw_n_o,
   output logic flag_select_n_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] data_o,
   output logic data_oe_o,
   input wire logic [DATA_W-1:0] data_i,
   input wire logic busy_n_i,
   input wire logic int_n_i
);
   dpc_state_type state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic we_r, we_nxt, flag_r, flag_nxt;
   logic ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, rw_n_r, rw_n_nxt, fs_n_r, fs_n_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [DATA_W-1:0] wdat_r, wdat_nxt, rdat_r, rdat_nxt;
   logic doe_r, doe_nxt, ready_r, ready_nxt, done_r, done_nxt, irq_r;
   logic [DATA_W-1:0] data_s;
   logic busy_n_s, int_n_s;
   logic [7:0] lim;

   dpc_sync #(.W(DATA_W), .RST_VAL(DATA_RST)) u_data_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .d_i(data_i),
      .q_o(data_s)
   );
   dpc_sync #(.W(2), .RST_VAL(2'h3)) u_ctl_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .d_i({busy_n_i, int_n_i}),
      .q_o({busy_n_s, int_n_s})
   );

   assign lim = we_r ? 8'(WRITE_CYCLES) : 8'(READ_CYCLES);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      we_nxt = we_r;
      flag_nxt = flag_r;
      ce_n_nxt = ce_n_r;
      oe_n_nxt = oe_n_r;
      rw_n_nxt = rw_n_r;
      fs_n_nxt = fs_n_r;
      addr_nxt = addr_r;
      wdat_nxt = wdat_r;
      rdat_nxt = rdat_r;
      doe_nxt = doe_r;
      ready_nxt = ready_r;
      done_nxt = 1'b0;
      case (state_r)
         DPC_IDLE: begin
            if (req_i && ready_r) begin
               // address moves only while deselected with read/write high
               addr_nxt = addr_i; // [R4] [R2]
               we_nxt = we_i;
               flag_nxt = flag_i;
               wdat_nxt = wdata_i;
               ready_nxt = 1'b0;
               state_nxt = DPC_SETUP;
            end
         end
         DPC_SETUP: begin
            // select after address is stable: select-controlled access
            ce_n_nxt = flag_r; // [R15] [R2]
            fs_n_nxt = ~flag_r; // [R15]
            if (we_r) begin
               rw_n_nxt = 1'b0;
               doe_nxt = 1'b1;
            end else begin
               rw_n_nxt = 1'b1; // [R1]
               oe_n_nxt = 1'b0;
            end
            cnt_nxt = CNT_RST;
            state_nxt = DPC_ACT;
         end
         DPC_ACT: begin
            if (!busy_n_s) begin
               // busy low restarts the timed pulse until it is released
               cnt_nxt = CNT_RST; // [R11] [R13]
            end else if (cnt_r >= lim - 8'h01) begin
               // the select rising first terminates the write
               ce_n_nxt = 1'b1; // [R3]
               fs_n_nxt = 1'b1; // [R3]
               oe_n_nxt = 1'b1;
               if (!we_r) begin
                  rdat_nxt = data_s; // [R14] [R16]
               end
               done_nxt = 1'b1;
               state_nxt = DPC_END;
            end else begin
               cnt_nxt = cnt_r + 8'h01;
            end
         end
         DPC_END: begin
            rw_n_nxt = 1'b1;
            cnt_nxt = CNT_RST;
            state_nxt = DPC_HOLD;
         end
         DPC_HOLD: begin
            doe_nxt = 1'b0;
            if (cnt_r >= 8'(RECOVER_CYCLES) - 8'h01) begin
               ready_nxt = 1'b1;
               state_nxt = DPC_IDLE;
            end else begin
               cnt_nxt = cnt_r + 8'h01;
            end
         end
         default: begin
            state_nxt = DPC_IDLE;
            ready_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_r <= DPC_IDLE;
         cnt_r <= CNT_RST;
         we_r <= 1'b0;
         flag_r <= 1'b0;
         ce_n_r <= 1'b1;
         oe_n_r <= 1'b1;
         rw_n_r <= 1'b1;
         fs_n_r <= 1'b1;
         addr_r <= ADDR_RST;
         wdat_r <= DATA_RST;
         rdat_r <= DATA_RST;
         doe_r <= 1'b0;
         ready_r <= 1'b1;
         done_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         we_r <= we_nxt;
         flag_r <= flag_nxt;
         ce_n_r <= ce_n_nxt;
         oe_n_r <= oe_n_nxt;
         rw_n_r <= rw_n_nxt;
         fs_n_r <= fs_n_nxt;
         addr_r <= addr_nxt;
         wdat_r <= wdat_nxt;
         rdat_r <= rdat_nxt;
         doe_r <= doe_nxt;
         ready_r <= ready_nxt;
         done_r <= done_nxt;
         irq_r <= ~int_n_s; // [R16]
      end
   end

   assign ce_n_o = ce_n_r;
   assign oe_n_o = oe_n_r;
   assign rw_n_o = rw_n_r;
   assign flag_select_n_o = fs_n_r;
   assign addr_o = addr_r;
   assign data_o = wdat_r; // [R7]
   assign data_oe_o = doe_r;
   assign ready_o = ready_r;
   assign done_o = done_r;
   assign rdata_o = rdat_r;
   assign irq_o = irq_r;

   // output enable low only with read/write high
   property p_read_rw_high;
      @(posedge sys_clk_i) disable iff (rst_i)
      !oe_n_r |-> rw_n_r && !doe_r;
   endproperty
   a_read_rw_high: assert property (p_read_rw_high) else $error("read with rw low"); // [R1]

   // address never moves while selected
   property p_select_ctl;
      @(posedge sys_clk_i) disable iff (rst_i)
      $changed(addr_r) |-> ce_n_r && fs_n_r && $past(ce_n_r) && $past(fs_n_r);
   endproperty
   a_select_ctl: assert property (p_select_ctl) else $error("address changed selected"); // [R2]

   // address changes only with read/write high
   property p_addr_rw;
      @(posedge sys_clk_i) disable iff (rst_i)
      $changed(addr_r) |-> rw_n_r && $past(rw_n_r);
   endproperty
   a_addr_rw: assert property (p_addr_rw) else $error("address changed rw low"); // [R4]

   // flag write: chip select high, data driven
   property p_flag_write;
      @(posedge sys_clk_i) disable iff (rst_i)
      (!fs_n_r && !rw_n_r) |-> ce_n_r && doe_r && $stable(data_o);
   endproperty
   a_flag_write: assert property (p_flag_write) else $error("bad flag write"); // [R7]

   // never both selects low
   property p_one_select;
      @(posedge sys_clk_i) disable iff (rst_i)
      !(ce_n_r == 1'b0 && fs_n_r == 1'b0);
   endproperty
   a_one_select: assert property (p_one_select) else $error("both selects low"); // [R15]

   // a write pulse ends with select rising, read/write one cycle later
   property p_write_end;
      @(posedge sys_clk_i) disable iff (rst_i)
      ($rose(ce_n_r) || $rose(fs_n_r)) && !rw_n_r |=> rw_n_r && doe_r ##1 !doe_r;
   endproperty
   a_write_end: assert property (p_write_end) else $error("write end order"); // [R3]
endmodule

// ===== hdl/dpc_pkg.sv
// shared constants for the two-port memory host controller
package dpc_pkg;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned ADDR_W = 13;
   localparam int unsigned DATA_W = 8;
   localparam logic [12:0] MAILBOX_ADDR = 13'h1FFE;
   localparam int unsigned T_READ_NS = 55;
   localparam int unsigned T_WRITE_NS = 45;
   localparam int unsigned T_RECOVER_NS = 5;
   localparam int unsigned SYNC_STAGES = 3;
   localparam int unsigned READ_CYC = (T_READ_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES;
   localparam int unsigned WRITE_CYC = (T_WRITE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RECOVER_CYC = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [12:0] ADDR_RST = 13'h0000;
   typedef enum logic [2:0] {
      DPC_IDLE,
      DPC_SETUP,
      DPC_ACT,
      DPC_END,
      DPC_HOLD
   } dpc_state_type;
endpackage

// ===== hdl/dpc_sync.sv
// three-stage pin synchroniser with agreement filter
module dpc_sync
   import dpc_pkg::*;
#(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_r, s2_r, s3_r, q_r;
   logic [W-1:0] q_nxt;

   // a bit changes only once stage two and three agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         q_r <= RST_VAL;
      end else begin
         s1_r <= d_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= q_nxt;
      end
   end

   assign q_o = q_r;
endmodule

// ===== testbench/dpc_dev_model.sv
// behavioural model of one port of the two-port memory
module dpc_dev_model
   import dpc_pkg::*;
(
   // port pins
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic rw_n_i,
   input wire logic flag_select_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] data_i,
   output logic [DATA_W-1:0] data_o,
   output logic busy_n_o,
   output logic int_n_o,
   // bench controls
   input wire logic hold_i,
   input wire logic peer_mail_i,
   input wire logic peer_claim_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [7:0] flags = 8'hFF;
   logic [DATA_W-1:0] last = 8'hFF;
   logic [DATA_W-1:0] wd;
   logic [ADDR_W-1:0] wa;
   logic wf;
   wire logic wr = !rw_n_i && (!ce_n_i || !flag_select_n_i) && !hold_i;
   wire logic rd = rw_n_i && !oe_n_i && (!ce_n_i || !flag_select_n_i);
   wire logic [DATA_W-1:0] rv = ce_n_i ? {DATA_W{flags[addr_i[2:0]]}} : mem[addr_i];
   logic int_r = 1'b1;
   logic peer_own = 1'b0;
   assign int_n_o = int_r;
   // busy low on this port only, standing for the losing side of a match
   assign busy_n_o = !hold_i;
   always @* begin
      if (wr) begin
         wa = addr_i;
         wd = data_i;
         wf = !flag_select_n_i;
      end
   end
   // first rising select or read/write ends the write
   always @(negedge wr) begin
      if (wf) begin
         // a flag already held by the far port stays with it
         if (!(peer_own && wa[2:0] == 3'h5)) flags[wa[2:0]] <= wd[0];
      end else begin
         mem[wa] <= wd;
      end
   end
   // the far port takes flag 5 while this port does not hold it
   always @(posedge peer_claim_i) begin
      if (flags[5]) peer_own <= 1'b1;
   end
   always @(rd or rv) begin
      if (rd) last = rv;
   end
   // released lines show the inverse of the last value
   assign data_o = rd ? rv : ~last;
   always @(posedge peer_mail_i or posedge rd) begin
      if (rd && !ce_n_i && addr_i == MAILBOX_ADDR) int_r <= 1'b1;
      else if (peer_mail_i && !rd) int_r <= 1'b0;
   end
endmodule

// ===== testbench/tb.sv
// self-checking bench for the two-port memory host controller
module tb;
   import dpc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic req_i = 1'b0;
   logic we_i = 1'b0;
   logic flag_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [DATA_W-1:0] wdata_i = '0;
   logic hold = 1'b0;
   logic peer_mail = 1'b0;
   logic peer_claim = 1'b0;
   logic ready_o, done_o, irq_o, ce_n, oe_n, rw_n, fsel_n, data_oe, busy_n, int_n;
   logic [DATA_W-1:0] rdata_o, dout, din;
   logic [ADDR_W-1:0] pin_addr;
   logic [7:0] sel;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int took;
   always #2.5 sys_clk_i = ~sys_clk_i;
   dpc_host i_dpc_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req_i), .we_i(we_i),
      .flag_i(flag_i), .addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o),
      .done_o(done_o), .rdata_o(rdata_o), .irq_o(irq_o), .ce_n_o(ce_n), .oe_n_o(oe_n),
      .rw_n_o(rw_n), .flag_select_n_o(fsel_n), .addr_o(pin_addr), .data_o(dout),
      .data_oe_o(data_oe), .data_i(din), .busy_n_i(busy_n), .int_n_i(int_n));
   dpc_dev_model i_dpc_dev_model (.ce_n_i(ce_n), .oe_n_i(oe_n), .rw_n_i(rw_n),
      .flag_select_n_i(fsel_n), .addr_i(pin_addr), .data_i(dout), .data_o(din),
      .busy_n_o(busy_n), .int_n_o(int_n), .hold_i(hold), .peer_mail_i(peer_mail),
      .peer_claim_i(peer_claim));
   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_n(input string what, input int lo, input int got);
      n_compared++;
      if (got < lo) begin
         fail_count++;
         $display("[FAIL] %s expected >= %0d seen %0d", what, lo, got);
      end
   endtask
   // one access; pin selects sampled after the select edge
   task automatic access(input logic w, f, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      while (ready_o !== 1'b1) @(negedge sys_clk_i);
      @(posedge sys_clk_i);
      req_i <= 1'b1;
      we_i <= w;
      flag_i <= f;
      addr_i <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      req_i <= 1'b0;
      took = 0;
      while (done_o !== 1'b1 && took < 2000) begin
         @(posedge sys_clk_i);
         if (took == 20) hold <= 1'b0;
         @(negedge sys_clk_i);
         took++;
         if (took == 3) sel = {3'h0, oe_n, data_oe, ce_n, fsel_n, rw_n};
      end
      check("access done", 8'h01, {7'h00, done_o});
      check("select pins", {3'h0, w, w, f, !f, !w}, sel);
   endtask
   task automatic t_array();
      access(1'b1, 1'b0, 13'h0155, 8'hA5);
      access(1'b1, 1'b0, 13'h1FFF, 8'h3C);
      access(1'b0, 1'b0, 13'h0155, 8'h00);
      check("array byte 0155", 8'hA5, rdata_o);
      access(1'b0, 1'b0, 13'h1FFF, 8'h00);
      check("array byte 1FFF", 8'h3C, rdata_o);
      $display("array test done");
   endtask
   task automatic t_flags();
      access(1'b0, 1'b1, 13'h0003, 8'h00);
      check("flag at start", 8'hFF, rdata_o);
      access(1'b1, 1'b1, 13'h0003, 8'hFE);
      access(1'b0, 1'b1, 13'h0003, 8'h00);
      check("flag after claim", 8'h00, rdata_o);
      $display("flag test done");
   endtask
   task automatic t_hold();
      @(posedge sys_clk_i);
      hold <= 1'b1;
      access(1'b1, 1'b0, 13'h0AAA, 8'h5A);
      check_n("hold-off cycles", 20 + WRITE_CYC, took);
      access(1'b0, 1'b0, 13'h0AAA, 8'h00);
      check("held write byte", 8'h5A, rdata_o);
      $display("hold-off test done");
   endtask
   task automatic t_contend();
      @(posedge sys_clk_i);
      peer_claim <= 1'b1;
      access(1'b1, 1'b1, 13'h0005, 8'hFE);
      access(1'b0, 1'b1, 13'h0005, 8'h00);
      check("flag held by peer", 8'hFF, rdata_o);
      $display("contention test done");
   endtask
   task automatic t_mail();
      @(posedge sys_clk_i);
      peer_mail <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      check("irq set", 8'h01, {7'h00, irq_o});
      access(1'b0, 1'b0, MAILBOX_ADDR, 8'h00);
      repeat (8) @(posedge sys_clk_i);
      check("irq cleared", 8'h00, {7'h00, irq_o});
      peer_mail <= 1'b0;
      $display("mailbox test done");
   endtask
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      repeat (6) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      t_flags();
      t_array();
      t_hold();
      t_contend();
      t_mail();
      final_report();
   end
endmodule
